// *** logic/vdp_pkg.sv ***
// constants, register map and state type of the variable duty pwm output
package vdp_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int          VDP_CLK_HZ    = 20_000_000;
  localparam logic [27:0] VDP_FINE_NUM  = 28'(VDP_CLK_HZ * 10);
  localparam logic [27:0] VDP_CO_NUM    = 28'(VDP_CLK_HZ);
  localparam logic [5:0]  VDP_DIV_STEPS = 6'h22;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] VDP_OFF_PORT   = 8'h00;
  localparam logic [7:0] VDP_OFF_FREQ   = 8'h04;
  localparam logic [7:0] VDP_OFF_DUTY   = 8'h08;
  localparam logic [7:0] VDP_OFF_START  = 8'h0c;
  localparam logic [7:0] VDP_OFF_CMD    = 8'h10;
  localparam logic [7:0] VDP_OFF_STATUS = 8'h14;
  localparam logic [7:0] VDP_OFF_ISTAT  = 8'h18;
  localparam logic [7:0] VDP_OFF_IMASK  = 8'h1c;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int VDP_START_GO  = 0;
  localparam int VDP_START_ISR = 1;
  localparam int VDP_EV_ERR    = 0;
  localparam int VDP_EV_START  = 1;
  localparam int VDP_EV_STOP   = 2;
  // ------------------------------------------------------------
  // operand codes and limits
  // ------------------------------------------------------------
  localparam logic [15:0] VDP_PORT_FINE   = 16'h1000;
  localparam logic [15:0] VDP_PORT_COARSE = 16'h1100;
  localparam logic [15:0] VDP_FINE_MIN    = 16'h0014;
  localparam logic [15:0] VDP_CO_MIN      = 16'h0002;
  localparam logic [15:0] VDP_CO_MAX      = 16'h7d00;
  localparam logic [15:0] VDP_DUTY_MAX    = 16'h03e8;
  localparam logic [27:0] VDP_DUTY_DIV    = 28'h00003e8;
  localparam logic [15:0] VDP_CMD_STOP    = 16'h0003;
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_DIVP, ST_DIVH} vdp_seq_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [15:0] port;
    logic [15:0] freq;
    logic [15:0] duty;
    logic [2:0]  imask;
    logic [2:0]  istat;
    logic        irq;
    logic        pwm;
    logic        err;
    logic        run;
    logic        owner_isr;
    logic        pend;
    logic        sup_done;
    logic        supported;
    logic        rs1, rs2, rs3, run_f;
    logic        os1, os2, os3, org_f;
    vdp_seq_t    st;
    logic [5:0]  dcnt;
    logic [33:0] dvd;
    logic [27:0] dvs;
    logic [28:0] rem;
    logic [23:0] period;
    logic [23:0] cnt;
    logic [23:0] high;
    logic [23:0] hpend;
  } vdp_state_t;
  localparam vdp_state_t VDP_RST = '0;
endpackage : vdp_pkg

// *** logic/vdp_pwm.sv ***
// variable duty pwm output channel with apb register file
// Operation
// - two port codes: fine and coarse frequency
// - fine frequency in 0.1 Hz, 2.0-6553.5 Hz
// - coarse frequency word in hertz, 2-32000 Hz
// - duty in 0.1 percent, above 1000 illegal
// - output high for duty fraction of period
// - error flag set on bad operand, else cleared
// - error if port busy with origin search
// - error if interrupt start steals cyclic output
// - new request updates duty without restart
// - frequency ignored while output runs
// - stop control code halts the output
// - leaving run mode halts the output
// - unsupported unit treats start as no-op
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module vdp_pwm
  import vdp_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        i_run_mode,
  input  wire logic        i_origin_busy,
  input  wire logic        i_pwm_supported,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  output logic             o_pwm,
  output logic             o_instr_error_flag,
  output logic             o_irq
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == VDP_OFF_PORT) || (a == VDP_OFF_FREQ) ||
                (a == VDP_OFF_DUTY) || (a == VDP_OFF_START) ||
                (a == VDP_OFF_CMD) || (a == VDP_OFF_STATUS) ||
                (a == VDP_OFF_ISTAT) || (a == VDP_OFF_IMASK);
  endfunction : is_mapped

  vdp_state_t  r;
  vdp_state_t  n;
  logic        wr;
  logic        start_req;
  logic        stop_wr;
  logic        fine;
  logic        coarse;
  logic        bad;
  logic        hit;
  logic        qbit;
  logic [28:0] rem_sh;
  logic [33:0] quo;
  logic [2:0]  ev;
  logic [2:0]  clr;

  assign wr        = i_psel && i_penable && r.pready && i_pwrite && is_mapped(i_paddr);
  assign start_req = wr && (i_paddr == VDP_OFF_START) && i_pwdata[VDP_START_GO];
  assign stop_wr   = wr && (i_paddr == VDP_OFF_CMD) && (i_pwdata[15:0] == VDP_CMD_STOP);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n      = r;
    fine   = 1'b0;
    coarse = 1'b0;
    bad    = 1'b0;
    hit    = 1'b0;
    ev     = 3'h0;
    clr    = 3'h0;
    // apb: one wait-free answer, data set up in the setup cycle
    n.pready  = i_psel && !r.pready;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0;
    if (i_psel && !r.pready) begin
      n.pslverr = !is_mapped(i_paddr);
      unique case (i_paddr)
        VDP_OFF_PORT:   n.prdata = {16'h0, r.port};
        VDP_OFF_FREQ:   n.prdata = {16'h0, r.freq};
        VDP_OFF_DUTY:   n.prdata = {16'h0, r.duty};
        VDP_OFF_STATUS: n.prdata = {28'h0, r.pend, r.pwm, r.err, r.run};
        VDP_OFF_ISTAT:  n.prdata = {29'h0, r.istat};
        VDP_OFF_IMASK:  n.prdata = {29'h0, r.imask};
        default:        n.prdata = 32'h0;
      endcase
    end
    // pins pass three flops; only agreeing late stages count
    n.rs1 = i_run_mode;
    n.rs2 = r.rs1;
    n.rs3 = r.rs2;
    if (r.rs2 == r.rs3) begin
      n.run_f = r.rs3;
    end
    n.os1 = i_origin_busy;
    n.os2 = r.os1;
    n.os3 = r.os2;
    if (r.os2 == r.os3) begin
      n.org_f = r.os3;
    end
    // strap caught once after reset release
    if (!r.sup_done) begin
      n.sup_done  = 1'b1;
      n.supported = i_pwm_supported;
    end
    // register writes
    if (wr) begin
      unique case (i_paddr)
        VDP_OFF_PORT:  n.port  = i_pwdata[15:0];
        VDP_OFF_FREQ:  n.freq  = i_pwdata[15:0];
        VDP_OFF_DUTY:  n.duty  = i_pwdata[15:0];
        VDP_OFF_IMASK: n.imask = i_pwdata[2:0];
        VDP_OFF_ISTAT: clr     = i_pwdata[2:0];
        default:       clr     = 3'h0;
      endcase
    end
    // start request; operands still checked, but no new division while one is running
    if (start_req && r.supported && r.run_f) begin
      fine   = (r.port == VDP_PORT_FINE);
      coarse = (r.port == VDP_PORT_COARSE);
      bad    = !(fine || coarse) || (r.duty > VDP_DUTY_MAX);
      bad    = bad || (fine && (r.freq < VDP_FINE_MIN));
      bad    = bad || (coarse && ((r.freq < VDP_CO_MIN) || (r.freq > VDP_CO_MAX)));
      hit    = bad || r.org_f;
      hit    = hit || (i_pwdata[VDP_START_ISR] && r.run && !r.owner_isr);
      n.err  = hit;
      ev[VDP_EV_ERR] = hit;
      if (!hit && (r.st == ST_IDLE)) begin
        n.dcnt = VDP_DIV_STEPS;
        n.rem  = 29'h0;
        if (r.run) begin
          // keep the running period, only the duty is recomputed
          n.st  = ST_DIVH;
          n.dvd = 34'(r.period) * 34'(r.duty[9:0]);
          n.dvs = VDP_DUTY_DIV;
        end else begin
          n.st        = ST_DIVP;
          n.dvd       = {6'h0, fine ? VDP_FINE_NUM : VDP_CO_NUM};
          n.dvs       = {12'h0, r.freq};
          n.owner_isr = i_pwdata[VDP_START_ISR];
        end
      end
    end
    // serial divider: one quotient bit per clock saves a wide divider
    rem_sh = {r.rem[27:0], r.dvd[33]};
    qbit   = (rem_sh >= {1'b0, r.dvs});
    quo    = {r.dvd[32:0], qbit};
    if (r.st != ST_IDLE) begin
      n.rem  = qbit ? (rem_sh - {1'b0, r.dvs}) : rem_sh;
      n.dvd  = quo;
      n.dcnt = r.dcnt - 6'h1;
      if (r.dcnt == 6'h1) begin
        n.rem = 29'h0;
        if (r.st == ST_DIVP) begin
          n.period = quo[23:0];
          n.dvd    = 34'(quo[23:0]) * 34'(r.duty[9:0]);
          n.dvs    = VDP_DUTY_DIV;
          n.dcnt   = VDP_DIV_STEPS;
          n.st     = ST_DIVH;
        end else begin
          n.st = ST_IDLE;
          if (r.run) begin
            n.hpend = quo[23:0];
            n.pend  = 1'b1;
          end else begin
            n.run  = 1'b1;
            n.cnt  = 24'h0;
            n.high = quo[23:0];
            ev[VDP_EV_START] = 1'b1;
          end
        end
      end
    end
    // period counter; duty swaps only at the wrap so no glitch
    if (r.run) begin
      if (r.cnt == (r.period - 24'h1)) begin
        n.cnt = 24'h0;
        if (r.pend) begin
          n.high = r.hpend;
          n.pend = 1'b0;
        end
      end else begin
        n.cnt = r.cnt + 24'h1;
      end
    end
    // stop wins over any start finishing in the same cycle
    if (stop_wr || !r.run_f) begin
      n.run  = 1'b0;
      n.pend = 1'b0;
      n.st   = ST_IDLE;
      ev[VDP_EV_STOP] = r.run;
    end
    // sticky events: set wins over a simultaneous clear
    n.istat = (r.istat & ~clr) | ev;
    n.pwm   = n.run && (n.cnt < n.high);
    n.irq   = |(n.istat & n.imask);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      r <= VDP_RST;
    end else begin
      r <= n;
    end
  end

  assign o_pready           = r.pready;
  assign o_pslverr          = r.pslverr;
  assign o_prdata           = r.prdata;
  assign o_pwm              = r.pwm;
  assign o_instr_error_flag = r.err;
  assign o_irq              = r.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_pwm_duty_level: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> (o_pwm == (r.run && (r.cnt < r.high))))
    else $error("pwm level does not follow duty threshold");

  a_bad_op_err: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (start_req && r.supported && r.run_f && (r.duty > VDP_DUTY_MAX)) |=> o_instr_error_flag)
    else $error("illegal duty did not raise error");

  a_busy_err: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (start_req && r.supported && r.run_f && r.org_f) |=> o_instr_error_flag)
    else $error("busy port did not raise error");

  a_isr_conflict: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (start_req && r.supported && r.run_f && i_pwdata[VDP_START_ISR] && r.run && !r.owner_isr)
    |=> o_instr_error_flag)
    else $error("interrupt start over cyclic output not flagged");

  a_no_restart: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (r.run && r.run_f && start_req) |=> (r.run && (r.cnt != 24'h0 || $past(r.cnt) == (r.period - 24'h1))))
    else $error("duty update restarted the waveform");

  a_freq_kept: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ($past(r.run) && r.run) |-> $stable(r.period))
    else $error("period changed while running");

  a_stop_cmd: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    stop_wr |=> (!r.run && !o_pwm))
    else $error("stop code did not halt output");

  a_run_exit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !r.run_f |=> (!r.run ##1 !o_pwm))
    else $error("output kept running outside run mode");

  a_nop_unsup: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (start_req && r.sup_done && !r.supported) |=> ($stable(o_instr_error_flag) && (r.st == ST_IDLE || $past(r.st) != ST_IDLE)))
    else $error("start on unsupported unit was not ignored");

  a_duty_boundary: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ($past(r.run) && r.run && (r.high != $past(r.high))) |-> ($past(r.cnt) == ($past(r.period) - 24'h1)))
    else $error("duty changed away from period boundary");

  a_irq_level: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> (o_irq == |(r.istat & r.imask)))
    else $error("interrupt output does not match masked status");

endmodule : vdp_pwm
`default_nettype wire

// *** dv/vdp_load.sv ***
// load model that measures period and high time of the pwm wave
`timescale 1ns/10ps
`default_nettype none
module vdp_load (
  input  wire logic   i_ref_clk,
  input  wire logic   i_pwm,
  output logic [23:0] o_per,
  output logic [23:0] o_hi
);
  // ------------------------------------------------------------
  // counters restart at each rising edge of the wave
  // ------------------------------------------------------------
  logic [23:0] cnt;
  logic [23:0] hcnt;
  logic        last;
  initial begin
    cnt   = '0;
    hcnt  = '0;
    last  = 1'b0;
    o_per = '0;
    o_hi  = '0;
  end
  // values only update on a full period, so a stopped wave keeps the last one
  always @(posedge i_ref_clk) begin
    last <= (i_pwm === 1'b1);
    if ((i_pwm === 1'b1) && !last) begin
      o_per <= cnt;
      o_hi  <= hcnt;
      cnt   <= 24'h000001;
      hcnt  <= 24'h000001;
    end else begin
      cnt  <= cnt + 24'h000001;
      hcnt <= hcnt + {23'h0, (i_pwm === 1'b1)};
    end
  end
endmodule : vdp_load
`default_nettype wire

// *** dv/variable_duty_pwm_output_bench.sv ***
// self-checking bench of the variable duty pwm output
`timescale 1ns/10ps
`default_nettype none
module variable_duty_pwm_output_bench;
  import vdp_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, run_mode, org_busy, supp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, pwm, errf, irq, e;
  logic [23:0] per, hi;
  int          failures, checked;
  logic [15:0] bp [5] = '{16'h1001, 16'h1100, 16'h1000, 16'h1100, 16'h1100};
  logic [15:0] bf [5] = '{16'h7d00, 16'h0001, 16'h0013, 16'h7d01, 16'h7d00};
  logic [15:0] bd [5] = '{16'h01f4, 16'h01f4, 16'h01f4, 16'h01f4, 16'h03e9};

  vdp_pwm uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_run_mode(run_mode),
    .i_origin_busy(org_busy), .i_pwm_supported(supp), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .o_pwm(pwm), .o_instr_error_flag(errf), .o_irq(irq));
  vdp_load load (.i_ref_clk(clk), .i_pwm(pwm), .o_per(per), .o_hi(hi));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // an idle edge after each transfer keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) failures++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, q, x);
  endtask : rd
  task automatic cfg(input logic [15:0] p, input logic [15:0] f, input logic [15:0] d);
    apb(1'b1, VDP_OFF_PORT, {16'h0, p});
    apb(1'b1, VDP_OFF_FREQ, {16'h0, f});
    apb(1'b1, VDP_OFF_DUTY, {16'h0, d});
  endtask : cfg
  task automatic go(input logic isr);
    apb(1'b1, VDP_OFF_START, {30'h0, isr, 1'b1});
    wt(3);
  endtask : go

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // whole run is near 11500 cycles
  initial begin
    wt(40000);
    failures++;
    report_and_stop;
  end
  initial begin
    failures = 0;
    checked  = 0;
    rst_n    = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    run_mode = 1'b1;
    org_busy = 1'b0;
    supp     = 1'b1;
    wt(10);
    rst_n <= 1'b1;
    wt(6);
    chk("pwm idle", pwm, 32'h0);
    rd(VDP_OFF_IMASK, 32'h0, "imask reset");
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", e, 32'h1);
    for (int i = 0; i < 5; i++) begin
      cfg(bp[i], bf[i], bd[i]);
      go(1'b0);
      chk("bad operand", errf, 32'h1);
    end
    cfg(VDP_PORT_COARSE, VDP_CO_MAX, 16'h01f4);
    go(1'b0);
    chk("error clear", errf, 32'h0);
    wt(2000);
    chk("period", per, 32'd625);
    chk("high", hi, 32'd312);
    org_busy <= 1'b1;
    wt(6);
    go(1'b0);
    chk("origin busy", errf, 32'h1);
    org_busy <= 1'b0;
    wt(6);
    // a valid start request clears the flag so the next check can only pass through the owner rule
    go(1'b0);
    chk("busy cleared", errf, 32'h0);
    wt(40);
    go(1'b1);
    chk("isr start", errf, 32'h1);
    wt(40);
    apb(1'b1, VDP_OFF_FREQ, 32'h0100);
    apb(1'b1, VDP_OFF_DUTY, 32'h00fa);
    go(1'b0);
    wt(700);
    chk("no restart", per, 32'd625);
    wt(1300);
    chk("new high", hi, 32'd156);
    chk("freq kept", per, 32'd625);
    apb(1'b1, VDP_OFF_CMD, {16'h0, VDP_CMD_STOP});
    wt(2);
    chk("stopped", pwm, 32'h0);
    rd(VDP_OFF_STATUS, 32'h0, "stop status");
    rd(VDP_OFF_ISTAT, 32'h7, "events");
    apb(1'b1, VDP_OFF_IMASK, 32'h4);
    wt(2);
    chk("irq set", irq, 32'h1);
    apb(1'b1, VDP_OFF_ISTAT, 32'h7);
    wt(2);
    chk("irq clear", irq, 32'h0);
    cfg(VDP_PORT_FINE, 16'hffff, 16'h0064);
    go(1'b0);
    wt(7000);
    chk("fine period", per, 32'd3051);
    chk("fine high", hi, 32'd305);
    run_mode <= 1'b0;
    wt(8);
    chk("program mode", pwm, 32'h0);
    rd(VDP_OFF_STATUS, 32'h0, "program mode status");
    run_mode <= 1'b1;
    supp     <= 1'b0;
    rst_n    <= 1'b0;
    wt(2);
    rst_n <= 1'b1;
    wt(8);
    cfg(VDP_PORT_COARSE, VDP_CO_MAX, 16'h01f4);
    go(1'b0);
    wt(200);
    chk("unsupported", pwm, 32'h0);
    rd(VDP_OFF_ISTAT, 32'h0, "no start");
    rd(VDP_OFF_STATUS, 32'h0, "unsupported status");
    report_and_stop;
  end
endmodule : variable_duty_pwm_output_bench
`default_nettype wire
